//--- sesus_map.svh
// Constants for the sector erase and suspend controller.
`ifndef SESUS_MAP_SVH
`define SESUS_MAP_SVH
`define SESUS_REG_CTRL      8'h00
`define SESUS_REG_SECTOR    8'h04
`define SESUS_REG_STATUS    8'h08
`define SESUS_REG_COUNT     8'h0C
`define SESUS_CMD_START     0
`define SESUS_CMD_ADD       1
`define SESUS_CMD_SUSPEND   2
`define SESUS_CMD_RESUME    3
`define SESUS_CMD_ABORT     4
`define SESUS_CMD_HWRESET   5
`define SESUS_CMD_POLL      6
`define SESUS_UNLOCK1_ADDR  12'h555
`define SESUS_UNLOCK2_ADDR  12'h2AA
`define SESUS_DATA_UNLOCK1  8'hAA
`define SESUS_DATA_UNLOCK2  8'h55
`define SESUS_DATA_SETUP    8'h80
`define SESUS_DATA_ERASE    8'h30
`define SESUS_DATA_SUSPEND  8'hB0
`define SESUS_DATA_RESUME   8'h30
`define SESUS_DATA_RESET    8'hF0
`define SESUS_SECTOR_LSB    15
`define SESUS_WINDOW_NS     50000
`define SESUS_CLK_NS        100
`define SESUS_WINDOW_CYC    ((`SESUS_WINDOW_NS) / (`SESUS_CLK_NS))
`define SESUS_WE_LOW_CYC    1
`define SESUS_RESET_CYC     5
`endif

//--- sesus_pkg.sv
// Types for the sector erase and suspend controller.
package sesus_pkg;
	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  data;
	} sesus_wcyc_t;
	typedef enum logic [2:0] {
		SESUS_IDLE,
		SESUS_SEQ,
		SESUS_QUEUE,
		SESUS_ERASING,
		SESUS_SUSPENDED
	} sesus_phase_t;
endpackage

//--- sesus_write_cycle.sv
// One asynchronous write cycle on the flash bus: address, data, write strobe pulse.
`timescale 1ns/1ps
`default_nettype none
module sesus_write_cycle (
	// Clock and reset
	input  wire logic                 clk_sys_in,
	input  wire logic                 reset_in,
	// Request side
	input  wire logic                 go_in,
	input  wire sesus_pkg::sesus_wcyc_t cyc_in,
	output logic                      busy_out,
	output logic                      done_out,
	// Flash pins
	output logic [19:0]               addr_out,
	output logic [7:0]                dq_out,
	output logic                      dq_oe_out,
	output logic                      we_n_out
);
	logic [1:0] phase;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			phase     <= 2'h0;
			busy_out  <= 1'b0;
			done_out  <= 1'b0;
			addr_out  <= 20'h00000;
			dq_out    <= 8'h00;
			dq_oe_out <= 1'b0;
			we_n_out  <= 1'b1;
		end else begin
			done_out <= 1'b0;
			case (phase)
				2'h0: if (go_in) begin
					addr_out  <= cyc_in.addr;
					dq_out    <= cyc_in.data;
					dq_oe_out <= 1'b1;
					busy_out  <= 1'b1;
					phase     <= 2'h1;
				end
				2'h1: begin
					we_n_out <= 1'b0;
					phase    <= 2'h2;
				end
				2'h2: begin
					// Data latches on the rising strobe edge, so data stays one more cycle.
					we_n_out <= 1'b1;
					phase    <= 2'h3;
				end
				default: begin
					dq_oe_out <= 1'b0;
					busy_out  <= 1'b0;
					done_out  <= 1'b1;
					phase     <= 2'h0;
				end
			endcase
		end
	end
endmodule // sesus_write_cycle
`default_nettype wire

//--- sesus_ctrl.sv
// Host controller that issues sector erase, queue, suspend and resume to a parallel flash.
//
// Summary of operation
// RQ1: Erase start is six writes: two unlocks, setup, two unlocks, sector plus erase.
// RQ2: Device hides secure region, identification and query while erasing; host avoids them.
// RQ3: Device preprograms sectors itself; host issues no preprogram writes.
// RQ4: Device waits fifty microseconds after last strobe before erasing.
// RQ5: Extra sector erase writes may be queued in any order inside the window.
// RQ6: Host spaces each queued sector write under fifty microseconds apart; adds go out when software asks, unchecked against the window.
// RQ7: Host should keep interrupts off while queuing sectors.
// RQ8: Any other write in the window aborts; host must restart whole sequence.
// RQ9: Erase timer flag shows window expiry; host may poll it.
// RQ10: Once erasing, device obeys only suspend; host sends nothing else.
// RQ11: Hardware reset stops erase; host reissues full sequence afterwards.
// RQ12: Device returns to array reads when done; ready busy shows progress.
// RQ13: Suspend is honoured only during sector erase or its window.
// RQ14: Suspend in window is immediate; during erase within twenty microseconds.
// RQ15: While suspended, reads in erasing sectors return status bits.
// RQ16: Status distinguishes active erase from suspended erase.
// RQ17: Program during suspend reports progress like normal programming.
// RQ18: Identification sequence allowed while suspended; exit returns to suspend.
// RQ19: Resume at any address continues erase; repeats ignored, new suspend allowed.
// RQ20: Each suspend redoes unfinished erase step, lengthening total time.
// RQ21: Suspend and resume are single writes with any address; resume code 30h.
// RQ22: Sector is selected by address bits nineteen down to fifteen.
// RQ23: Ready busy is busy from window end to completion, ready while suspended.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sesus_map.svh"
module sesus_ctrl #(
	parameter int WINDOW_CYC = `SESUS_WINDOW_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        reset_in,
	// Software register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic [31:0]      reg_rdata_out,
	// Flash pins
	output logic [19:0]      flash_addr_out,
	output logic [7:0]       flash_dq_out,
	output logic             flash_dq_oe_out,
	input  wire logic [7:0]  flash_dq_in,
	output logic             flash_we_n_out,
	output logic             flash_oe_n_out,
	output logic             flash_reset_n_out,
	input  wire logic        flash_ready_busy_in
);
	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] rb_sync;
	logic       rb_level;
	logic [7:0] dq_s1;
	logic [7:0] dq_s2;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			rb_sync  <= 3'h0;
			rb_level <= 1'b0;
		end else begin
			rb_sync <= {rb_sync[1:0], flash_ready_busy_in};
			if (rb_sync[1] == rb_sync[2])
				rb_level <= rb_sync[2];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
		end else begin
			dq_s1 <= flash_dq_in;
			dq_s2 <= dq_s1;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	sesus_pkg::sesus_phase_t phase;
	sesus_pkg::sesus_wcyc_t  seq [0:5];
	sesus_pkg::sesus_wcyc_t  cur;
	logic [2:0]  idx;
	logic [2:0]  last_idx;
	logic        go;
	logic        wbusy;
	logic        wdone;
	logic        issued;
	logic [4:0]  sector;
	logic [15:0] since_last;
	logic [15:0] queued;
	logic        window_late;
	logic        hw_cnt_run;
	logic [3:0]  hw_cnt;
	logic [7:0]  last_status;
	logic [1:0]  rd_phase;

	wire do_cmd = reg_wr_in && (reg_addr_in == `SESUS_REG_CTRL);
	wire [4:0] sec_w = reg_wdata_in[4:0];
	wire [19:0] sec_addr = {sec_w, 15'h0000}; // [RQ22]

	always_comb begin
		seq[0] = '{addr: {8'h00, `SESUS_UNLOCK1_ADDR}, data: `SESUS_DATA_UNLOCK1};
		seq[1] = '{addr: {8'h00, `SESUS_UNLOCK2_ADDR}, data: `SESUS_DATA_UNLOCK2};
		seq[2] = '{addr: {8'h00, `SESUS_UNLOCK1_ADDR}, data: `SESUS_DATA_SETUP};
		seq[3] = '{addr: {8'h00, `SESUS_UNLOCK1_ADDR}, data: `SESUS_DATA_UNLOCK1};
		seq[4] = '{addr: {8'h00, `SESUS_UNLOCK2_ADDR}, data: `SESUS_DATA_UNLOCK2};
		seq[5] = '{addr: {sector, 15'h0000}, data: `SESUS_DATA_ERASE};
	end

	sesus_write_cycle u_wcyc (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.go_in      (go),
		.cyc_in     (cur),
		.busy_out   (wbusy),
		.done_out   (wdone),
		.addr_out   (flash_addr_out),
		.dq_out     (flash_dq_out),
		.dq_oe_out  (flash_dq_oe_out),
		.we_n_out   (flash_we_n_out)
	);

	// Commands other than hardware reset are accepted only while no write cycle runs; others are dropped quietly.
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			phase    <= sesus_pkg::SESUS_IDLE;
			idx      <= 3'h0;
			last_idx <= 3'h0;
			go       <= 1'b0;
			cur      <= '0;
			issued   <= 1'b0;
			sector   <= 5'h00;
			queued   <= 16'h0000;
		end else begin
			go <= 1'b0;
			if (do_cmd && reg_wdata_in[`SESUS_CMD_HWRESET]) begin
				phase  <= sesus_pkg::SESUS_IDLE; // [RQ11]
				queued <= 16'h0000;
			end else if (phase == sesus_pkg::SESUS_SEQ) begin
				if (!wbusy && !go && !issued && rd_phase == 2'h0) begin
					cur    <= seq[idx]; // [RQ1]
					go     <= 1'b1;
					issued <= 1'b1;
				end else if (wdone) begin
					issued <= 1'b0;
					if (idx == 3'h5)
						phase <= sesus_pkg::SESUS_QUEUE; // [RQ4]
					else
						idx <= idx + 3'h1;
				end
			end else if (!wbusy && !go && do_cmd) begin
				if (reg_wdata_in[`SESUS_CMD_START] && phase == sesus_pkg::SESUS_IDLE) begin
					sector <= sec_w;
					idx    <= 3'h0;
					issued <= 1'b0;
					queued <= 16'h0001;
					phase  <= sesus_pkg::SESUS_SEQ;
				end else if (reg_wdata_in[`SESUS_CMD_ADD] && phase == sesus_pkg::SESUS_QUEUE) begin
					cur    <= '{addr: sec_addr, data: `SESUS_DATA_ERASE}; // [RQ5] [RQ6] [RQ7]
					go     <= 1'b1;
					queued <= queued + 16'h0001;
				end else if (reg_wdata_in[`SESUS_CMD_SUSPEND] &&
						(phase == sesus_pkg::SESUS_QUEUE || phase == sesus_pkg::SESUS_ERASING)) begin
					cur   <= '{addr: 20'h00000, data: `SESUS_DATA_SUSPEND}; // [RQ13] [RQ21]
					go    <= 1'b1;
					phase <= sesus_pkg::SESUS_SUSPENDED; // [RQ14]
				end else if (reg_wdata_in[`SESUS_CMD_RESUME] && phase == sesus_pkg::SESUS_SUSPENDED) begin
					cur   <= '{addr: 20'h00000, data: `SESUS_DATA_RESUME}; // [RQ19] [RQ21]
					go    <= 1'b1;
					phase <= sesus_pkg::SESUS_ERASING;
				end else if (reg_wdata_in[`SESUS_CMD_ABORT] && phase == sesus_pkg::SESUS_QUEUE) begin
					cur    <= '{addr: 20'h00000, data: `SESUS_DATA_RESET}; // [RQ8]
					go     <= 1'b1;
					phase  <= sesus_pkg::SESUS_IDLE;
					queued <= 16'h0000;
				end
			end else if (phase == sesus_pkg::SESUS_QUEUE && window_late && rb_level == 1'b0) begin
				phase <= sesus_pkg::SESUS_ERASING; // [RQ9] [RQ23]
			end else if (phase == sesus_pkg::SESUS_ERASING && window_late && rb_level) begin
				phase <= sesus_pkg::SESUS_IDLE; // [RQ12]
			end
		end
	end

	// Window timer measured from the end of each erase write.
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			since_last  <= 16'h0000;
			window_late <= 1'b0;
		// The timer clears to zero while suspended, so a long suspend cannot end the erase early on resume.
		end else if (wdone || phase == sesus_pkg::SESUS_IDLE || phase == sesus_pkg::SESUS_SEQ ||
				phase == sesus_pkg::SESUS_SUSPENDED) begin
			since_last  <= 16'h0000;
			window_late <= 1'b0;
		end else if (since_last != 16'hFFFF) begin
			since_last <= since_last + 16'h0001;
			if (since_last >= 16'(WINDOW_CYC))
				window_late <= 1'b1;
		end
	end

	// Status poll read on the flash bus; also drives the hardware reset pulse.
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			flash_oe_n_out    <= 1'b1;
			flash_reset_n_out <= 1'b0;
			hw_cnt_run        <= 1'b1;
			hw_cnt            <= 4'h0;
			rd_phase          <= 2'h0;
			last_status       <= 8'h00;
		end else begin
			if (do_cmd && reg_wdata_in[`SESUS_CMD_HWRESET]) begin
				hw_cnt_run        <= 1'b1;
				hw_cnt            <= 4'h0;
				flash_reset_n_out <= 1'b0;
			end else if (hw_cnt_run) begin
				hw_cnt <= hw_cnt + 4'h1;
				if (hw_cnt == 4'(`SESUS_RESET_CYC)) begin
					hw_cnt_run        <= 1'b0;
					flash_reset_n_out <= 1'b1;
				end
			end
			case (rd_phase)
				2'h0: if (do_cmd && reg_wdata_in[`SESUS_CMD_POLL] && !wbusy && !go) begin
					flash_oe_n_out <= 1'b0; // [RQ15] [RQ16]
					rd_phase       <= 2'h1;
				end
				2'h1: rd_phase <= 2'h2;
				2'h2: rd_phase <= 2'h3;
				default: begin
					last_status    <= dq_s2;
					flash_oe_n_out <= 1'b1;
					rd_phase       <= 2'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (reg_rd_in) begin
			if (reg_addr_in == `SESUS_REG_STATUS)
				reg_rdata_out <= {16'h0000, last_status, rb_level, window_late, wbusy, 2'h0, 3'(phase)};
			else if (reg_addr_in == `SESUS_REG_SECTOR)
				reg_rdata_out <= {27'h0000000, sector};
			else if (reg_addr_in == `SESUS_REG_COUNT)
				reg_rdata_out <= {16'h0000, queued};
			else
				reg_rdata_out <= 32'h00000000;
		end else begin
			reg_rdata_out <= 32'h00000000;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_seq_order: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ1]
		(go && phase == sesus_pkg::SESUS_SEQ && idx == 3'h2) |-> cur.data == `SESUS_DATA_SETUP)
		else $error("setup write out of order");
	chk_suspend_code: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ13]
		(go && cur.data == `SESUS_DATA_SUSPEND) |=> phase == sesus_pkg::SESUS_SUSPENDED)
		else $error("suspend without suspended phase");
	chk_resume_phase: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ19]
		(go && cur.data == `SESUS_DATA_RESUME && phase != sesus_pkg::SESUS_QUEUE && phase != sesus_pkg::SESUS_SEQ) |->
		phase == sesus_pkg::SESUS_ERASING && $past(phase) == sesus_pkg::SESUS_SUSPENDED)
		else $error("resume outside suspended erase");
	chk_erase_quiet: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ10]
		(go && $past(phase) == sesus_pkg::SESUS_ERASING) |-> cur.data == `SESUS_DATA_SUSPEND)
		else $error("non suspend write while erasing");
	chk_sector_bits: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ22]
		(go && cur.data == `SESUS_DATA_ERASE && phase == sesus_pkg::SESUS_QUEUE) |-> cur.addr[14:0] == 15'h0000)
		else $error("sector write with low address bits");
	chk_abort_idle: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ8]
		(go && cur.data == `SESUS_DATA_RESET) |-> phase == sesus_pkg::SESUS_IDLE)
		else $error("abort did not return to idle");
	chk_we_pulse: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ21]
		$fell(flash_we_n_out) |=> flash_we_n_out)
		else $error("write strobe longer than one cycle");
	chk_hw_reset: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ11]
		(do_cmd && reg_wdata_in[`SESUS_CMD_HWRESET]) |=> !flash_reset_n_out && phase == sesus_pkg::SESUS_IDLE)
		else $error("hardware reset not applied");
endmodule // sesus_ctrl
`default_nettype wire

//--- sesus_flash_model.sv
// Behavioural parallel flash that answers the controller's erase and suspend writes.
`timescale 1ns/1ps
`default_nettype none
module sesus_flash_model #(
	parameter int          ERASE_US = 40,
	parameter logic [7:0]  ID_CODE  = 8'h5A // Arbitrary value.
) (
	// Flash pins
	input  wire logic [19:0] addr_in,
	input  wire logic [7:0]  dq_in,
	input  wire logic        we_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        reset_n_in,
	output logic [7:0]       dq_out,
	output logic             ready_busy_out
);
	// ----------------------------------------
	// Command decoder and internal timing
	// ----------------------------------------
	// States: 0..5 sequence, 6 window, 7 erasing, 8 suspended, 9 suspend pending, 10 identification.
	int          st   = 0;
	int          tm   = 0;
	int          nsec = 0;
	logic [19:0] wa[$];
	logic [7:0]  wd[$];
	logic        tg   = 1'b0;
	logic        eg   = 1'b0;
	logic [7:0]  last = 8'h00;
	logic [7:0]  rd_val;
	always @(posedge we_n_in) begin
		wa.push_back(addr_in);
		wd.push_back(dq_in);
		if (!reset_n_in) begin
		end else if (st < 5) begin
			st = (addr_in[11:0] == ((st == 1 || st == 4) ? 12'h2AA : 12'h555) &&
				dq_in == (st == 2 ? 8'h80 : (st == 1 || st == 4) ? 8'h55 : 8'hAA)) ? st + 1 : 0;
		end else if (st == 5) begin
			nsec = 1;
			tm = 50;
			st = (dq_in == 8'h30) ? 6 : 0;
		end else if (st == 6) begin
			if (dq_in == 8'h30) begin
				nsec++;
				tm = 50;
			end else
				st = (dq_in == 8'hB0) ? 8 : 0;
		end else if (st == 7 && dq_in == 8'hB0) begin
			st = 9;
			tm = 5;
		end else if (st == 8 && dq_in == 8'h30) begin
			st = 7;
			tm = ERASE_US;
		end else if (st == 8 && dq_in == 8'h90) begin
			st = 10;
		end else if (st == 10 && dq_in == 8'hF0) begin
			st = 8;
		end
	end
	// The timer ticks once a microsecond; that is coarse but well inside every window.
	always #1000 begin
		if (tm > 0)
			tm = tm - 1;
		else if (st == 6) begin
			st = 7;
			tm = ERASE_US;
		end else if (st == 7)
			st = 0;
		else if (st == 9)
			st = 8;
	end
	always @(negedge reset_n_in) begin
		st = 0;
		tm = 0;
	end
	always @(negedge oe_n_in) begin
		if (st == 7 || st == 9)
			tg = ~tg;
		if (st >= 7)
			eg = ~eg;
	end
	always @(posedge oe_n_in)
		last = rd_val;
	assign rd_val = (st == 10) ? ID_CODE :
		(st >= 6) ? {st == 8, tg, 2'b00, st >= 7, eg, 2'b00} : 8'hFF;
	// A released bus shows the inverse of its last value rather than holding it.
	assign dq_out = !oe_n_in ? rd_val : ~last;
	assign ready_busy_out = !(st == 7 || st == 9);
endmodule // sesus_flash_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the sector erase and suspend controller.
`timescale 1ns/1ps
`default_nettype none
`include "sesus_map.svh"
module testbench;
	// ----------
	// Signals
	// ----------
	logic        clk_sys_in = 1'b0;
	logic        reset_in   = 1'b1;
	logic [7:0]  ra         = 8'h00;
	logic [31:0] rw         = 32'h0;
	logic        wr_s       = 1'b0;
	logic        rd_s       = 1'b0;
	logic [31:0] rdat, d;
	logic [19:0] fa;
	logic [7:0]  fo, fm, bus;
	logic        foe, fwe_n, foe_n, frst_n, frb;
	int          n_mismatch  = 0;
	int          checks_done = 0;
	int          seed        = 32'h5706;
	int          n_add;
	always #50 clk_sys_in = ~clk_sys_in;
	assign bus = foe ? fo : fm;
	sesus_ctrl dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(ra), .reg_wdata_in(rw),
		.reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdat), .flash_addr_out(fa), .flash_dq_out(fo),
		.flash_dq_oe_out(foe), .flash_dq_in(bus), .flash_we_n_out(fwe_n), .flash_oe_n_out(foe_n),
		.flash_reset_n_out(frst_n), .flash_ready_busy_in(frb));
	sesus_flash_model flash (.addr_in(fa), .dq_in(bus), .we_n_in(fwe_n), .oe_n_in(foe_n),
		.reset_n_in(frst_n), .dq_out(fm), .ready_busy_out(frb));
	// ----------
	// Tasks
	// ----------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_in);
		ra <= a;
		rw <= v;
		wr_s <= 1'b1;
		@(posedge clk_sys_in);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_in);
		ra <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys_in);
		rd_s <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic cmd(input int n);
		wr(`SESUS_REG_CTRL, 32'h1 << n);
		repeat (10) @(posedge clk_sys_in);
	endtask
	task automatic phase_is(input logic [2:0] p, input int lim);
		for (int k = 0; k < lim; k++) begin
			rd(`SESUS_REG_STATUS);
			if (d[2:0] === p)
				break;
		end
		check("phase", {29'h0, d[2:0]}, {29'h0, p});
	endtask
	task automatic poll;
		cmd(`SESUS_CMD_POLL);
		rd(`SESUS_REG_STATUS);
	endtask
	function automatic logic [27:0] seq_word(input int i);
		case (i)
			0, 3: return {20'h00555, 8'hAA};
			1, 4: return {20'h002AA, 8'h55};
			2: return {20'h00555, 8'h80};
			default: return {20'h08000, 8'h30};
		endcase
	endfunction
	task automatic print_verdict;
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#3000000;
		n_mismatch++;
		print_verdict;
	end
	// ----------
	// Scenarios
	// ----------
	initial begin
		int b;
		logic [31:0] sa;
		repeat (3) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		repeat (12) @(posedge clk_sys_in);
		check("reset pin", {31'h0, frst_n}, 32'h1);
		rd(8'h40);
		check("unmapped", d, 32'h0);
		b = flash.wa.size();
		cmd(`SESUS_CMD_SUSPEND);
		check("idle suspend", flash.wa.size() - b, 0);
		cmd(`SESUS_CMD_START);
		phase_is(3'd2, 60);
		for (int i = 0; i < 6; i++)
			check("sequence", {4'h0, flash.wa[b + i], flash.wd[b + i]}, {4'h0, seq_word(i)});
		n_add = $unsigned($random(seed)) % 4;
		repeat (n_add) begin
			repeat ($unsigned($random(seed)) % 100 + 5) @(posedge clk_sys_in);
			b = flash.wa.size();
			sa = ($unsigned($random(seed)) % 32) | 2;
			wr(`SESUS_REG_CTRL, sa);
			repeat (10) @(posedge clk_sys_in);
			check("added", {4'h0, flash.wa[b], flash.wd[b]}, {4'h0, sa[4:0], 15'h0000, 8'h30});
		end
		check("queued", flash.nsec, n_add + 1);
		phase_is(3'd3, 400);
		poll;
		check("erase flags", {30'h0, d[15], d[11]}, 32'h1);
		b = flash.wa.size();
		cmd(`SESUS_CMD_ADD);
		check("erasing add", flash.wa.size() - b, 0);
		for (int r = 0; r < 2; r++) begin
			b = flash.wa.size();
			cmd(`SESUS_CMD_SUSPEND);
			phase_is(3'd4, 110);
			check("suspend code", {24'h0, flash.wd[b]}, 32'hB0);
			repeat (210) @(posedge clk_sys_in);
			poll;
			check("suspend flags", {30'h0, d[15], d[7]}, 32'h3);
			b = flash.wa.size();
			cmd(`SESUS_CMD_RESUME);
			phase_is(3'd3, 60);
			check("resume code", {24'h0, flash.wd[b]}, 32'h30);
		end
		phase_is(3'd0, 600);
		cmd(`SESUS_CMD_START);
		phase_is(3'd2, 60);
		cmd(`SESUS_CMD_ABORT);
		phase_is(3'd0, 30);
		check("abort code", {24'h0, flash.wd[flash.wd.size() - 1]}, 32'hF0);
		check("abort state", flash.st, 0);
		cmd(`SESUS_CMD_START);
		phase_is(3'd2, 60);
		cmd(`SESUS_CMD_SUSPEND);
		phase_is(3'd4, 10);
		check("window suspend", flash.st, 8);
		cmd(`SESUS_CMD_RESUME);
		phase_is(3'd3, 60);
		cmd(`SESUS_CMD_HWRESET);
		phase_is(3'd0, 40);
		check("reset state", flash.st, 0);
		print_verdict;
	end
endmodule // testbench
`default_nettype wire
